// File: hdl/mss_defs.svh
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
`define MSS_CLK_MHZ        40
`define MSS_SAMPLE_DLY_NS  40
`define MSS_SAMPLE_DLY_CYC ((`MSS_SAMPLE_DLY_NS * `MSS_CLK_MHZ) / 1000)
`define MSS_SYNC_TOL_CYC   2
`define MSS_CH1_BITS       50
`define MSS_CH2_BITS       10
`define MSS_DRV_LO_END     8'h3F
`define MSS_DRV_HI_BEG     8'h60
`define MSS_DRV_HI_END     8'h6F
`define MSS_S1_END         8'h7F
`define MSS_S2_END         8'h3F
`define MSS_MIRROR_BEG     8'h40
`define MSS_MIRROR_END     8'h7F
`define MSS_QM_LINK_BIT    7
`endif

// File: hdl/mss_pkg.sv
package mss_pkg;
    typedef enum logic [1:0]
    {
        MSS_BLK_DRIVE,
        MSS_BLK_SAFE1,
        MSS_BLK_SAFE2
    } mss_blk_t;

    typedef struct packed
    {
        logic valid;
        logic mirror;
        logic [6:0] addr;
    } mss_dec_t;

    typedef struct packed
    {
        logic       fast_new;
        logic       fast_requested;
        logic       fast_enc_err;
        logic       fast_code_err;
        logic       fast_crc_err;
        logic       realign;
        logic       resync;
        logic       acc_invalid;
    } mss_fast_evt_t;

    typedef struct packed
    {
        logic       safe_new;
        logic       safe_code_err;
        logic       safe_crc_err;
        logic       safe_stale;
        logic       enc_pos_err;
    } mss_safe_evt_t;
endpackage : mss_pkg

// File: hdl/mss_status_outputs.sv
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_status_outputs
    import mss_pkg::*;
#(
    parameter int CNT_W  = 8,
    parameter int DEV_W  = 16,
    parameter int POS_W  = 32
)
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [15:0]         drive_event,
    input  wire logic [15:0]         drive_mask,
    input  wire logic                drive_event_wr,
    input  wire logic [7:0]          safe_event,
    input  wire logic [7:0]          safe_mask,
    input  wire logic                safe_event_wr,
    input  wire logic                spi_ss_n,
    output logic                     interrupt,
    output logic                     interrupt_s,
    input  wire logic [7:0]          master_quality_monitor_reg,
    input  wire logic                comm_fault,
    output logic                     link,
    input  wire mss_fast_evt_t       fast_evt,
    input  wire logic                pos_ready_all,
    output logic                     fast_pos_rdy,
    input  wire logic                sync,
    input  wire logic                trigger_edge_polarity,
    input  wire logic                frame_sync_tick,
    input  wire logic                synchronizing,
    output logic                     sync_edge,
    output logic                     sync_locked,
    input  wire logic                bigend,
    input  wire mss_blk_t            host_blk,
    input  wire logic [7:0]          host_addr,
    output mss_dec_t                 host_dec,
    input  wire logic                bit_sampled,
    output logic                     sample,
    input  wire mss_safe_evt_t       safe_evt,
    input  wire logic [POS_W-1:0]    safe_pos,
    input  wire logic [DEV_W-1:0]    acc_limit,
    input  wire logic [DEV_W-1:0]    max_deviation,
    output logic [POS_W-1:0]         est_pos,
    output logic [DEV_W-1:0]         worst_dev,
    output logic                     estimator_on,
    output logic                     dev_thr_err,
    output logic                     safe_channel_err,
    output logic                     safe_pos_err,
    output logic                     acceleration_err,
    input  wire logic [CNT_W-1:0]    acc_thr,
    output logic [CNT_W-1:0]         acc_err_cnt,
    output logic                     acc_thr_err,
    input  wire logic                frame_done,
    input  wire logic                frame_code_err,
    output logic                     encoding_err
);
    localparam int DLY = (`MSS_SAMPLE_DLY_CYC < 1) ? 1 : `MSS_SAMPLE_DLY_CYC;

    // ************************************************************
    // Reset and input synchronisers.
    // ************************************************************
    logic rst_m;
    logic rst_n;
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic ss_m;
    logic ss_s;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
            ss_m   <= 1'b1;
            ss_s   <= 1'b1;
        end
        else
        begin
            sync_m <= sync;
            sync_s <= sync_m;
            sync_d <= sync_s;
            ss_m   <= spi_ss_n;
            ss_s   <= ss_m;
        end
    end

    // ************************************************************
    // Interrupt outputs with write masking.
    // ************************************************************
    logic drv_wr_mask;
    logic saf_wr_mask;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_wr_mask <= 1'b0;
            saf_wr_mask <= 1'b0;
        end
        else
        begin
            if (drive_event_wr)
                drv_wr_mask <= 1'b1;
            else if (ss_s)
                drv_wr_mask <= 1'b0;
            if (safe_event_wr)
                saf_wr_mask <= 1'b1;
            else if (ss_s)
                saf_wr_mask <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interrupt   <= 1'b0;
            interrupt_s <= 1'b0;
        end
        else
        begin
            interrupt   <= |(drive_event & drive_mask) & ~drv_wr_mask & ~drive_event_wr;
            interrupt_s <= |(safe_event & safe_mask) & ~saf_wr_mask & ~safe_event_wr;
        end
    end

    // ************************************************************
    // Link indicator.
    // ************************************************************
    assign link = master_quality_monitor_reg[`MSS_QM_LINK_BIT] & ~comm_fault;

    // ************************************************************
    // Sampling trigger and position ready strobe.
    // ************************************************************
    logic [3:0] edge_age;
    logic       edge_pend;

    assign sync_edge = trigger_edge_polarity ? (sync_s & ~sync_d) : (~sync_s & sync_d);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fast_pos_rdy <= 1'b0;
        end
        else
        begin
            fast_pos_rdy <= fast_evt.fast_new & (pos_ready_all | fast_evt.fast_requested);
        end
    end

    // ************************************************************
    // Sync lock: distance from trigger edge to frame alignment.
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_age  <= 4'h0;
            edge_pend <= 1'b0;
        end
        else
        begin
            if (sync_edge)
            begin
                edge_pend <= 1'b1;
                edge_age  <= 4'h0;
            end
            else if (edge_pend && edge_age != 4'hF)
                edge_age <= edge_age + 4'h1;
            if (frame_sync_tick)
                edge_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_locked <= 1'b0;
        else if (synchronizing)
            sync_locked <= 1'b0;
        else if (frame_sync_tick && sync_edge)
            sync_locked <= 1'b1;
        else if (frame_sync_tick && edge_pend)
            sync_locked <= (edge_age < 4'(`MSS_SYNC_TOL_CYC));
    end

    // ************************************************************
    // Register block decoding and byte order.
    // ************************************************************
    function automatic mss_dec_t decode(input mss_blk_t blk, input logic [7:0] a,
                                        input logic be);
        mss_dec_t d;
        d.addr   = be ? {a[6:2], ~a[1:0]} : a[6:0];
        d.mirror = (a >= `MSS_MIRROR_BEG) && (a <= `MSS_MIRROR_END);
        case (blk)
            MSS_BLK_DRIVE: d.valid = (a <= `MSS_MIRROR_END);
            MSS_BLK_SAFE1: d.valid = (a <= `MSS_S1_END);
            MSS_BLK_SAFE2: d.valid = (a <= `MSS_S2_END);
            default:       d.valid = 1'b0;
        endcase
        if (blk == MSS_BLK_SAFE2)
            d.mirror = 1'b0;
        return d;
    endfunction : decode

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            host_dec <= '0;
        else
            host_dec <= decode(host_blk, host_addr, bigend);
    end

    // ************************************************************
    // Sample test output delayed behind the line driver.
    // ************************************************************
    logic [DLY-1:0] samp_pipe;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp_pipe <= '0;
            sample    <= 1'b0;
        end
        else
        begin
            samp_pipe <= DLY'({samp_pipe, bit_sampled});
            sample    <= samp_pipe[DLY-1];
        end
    end

    // ************************************************************
    // Estimator and diagnostics.
    // ************************************************************
    logic [POS_W-1:0] safe_prev;
    logic [POS_W-1:0] safe_last;
    logic             safe_seen;
    logic             est_cause;

    assign est_cause = fast_evt.fast_enc_err | fast_evt.fast_code_err | fast_evt.fast_crc_err
                     | fast_evt.realign | fast_evt.resync;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            safe_prev <= '0;
            safe_last <= '0;
            safe_seen <= 1'b0;
        end
        else if (safe_evt.safe_new)
        begin
            safe_prev <= safe_last;
            safe_last <= safe_pos;
            safe_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            est_pos      <= '0;
            worst_dev    <= '0;
            estimator_on <= 1'b0;
        end
        else if (fast_evt.fast_new)
        begin
            estimator_on <= est_cause;
            if (est_cause)
            begin
                est_pos   <= safe_last + (safe_last - safe_prev);
                worst_dev <= (worst_dev > ~acc_limit) ? '1 : worst_dev + acc_limit;
            end
            else
                worst_dev <= '0;
        end
    end

    assign dev_thr_err = (worst_dev > max_deviation);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            safe_channel_err <= 1'b0;
            safe_pos_err     <= 1'b1;
        end
        else
        begin
            if (safe_evt.safe_new)
                safe_channel_err <= safe_evt.safe_code_err | safe_evt.safe_crc_err;
            safe_pos_err <= ~safe_seen | safe_evt.safe_stale | safe_evt.enc_pos_err;
        end
    end

    logic acc_cause;

    assign acc_cause = fast_evt.fast_code_err | fast_evt.acc_invalid;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acceleration_err <= 1'b0;
            acc_err_cnt      <= '0;
        end
        else if (fast_evt.fast_new)
        begin
            acceleration_err <= acc_cause;
            if (acc_cause)
                acc_err_cnt <= (acc_err_cnt == '1) ? acc_err_cnt : acc_err_cnt + 1'b1;
            else
                acc_err_cnt <= '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            encoding_err <= 1'b0;
        else if (frame_done)
            encoding_err <= frame_code_err;
    end

    assign acc_thr_err = (acc_err_cnt > acc_thr);
endmodule : mss_status_outputs

// File: tb/mss_checker.sv
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_checker
    import mss_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int DEV_W = 16
)
(
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic [15:0]      drive_event,
    input wire logic [15:0]      drive_mask,
    input wire logic             drive_event_wr,
    input wire logic [7:0]       safe_event,
    input wire logic [7:0]       safe_mask,
    input wire logic             safe_event_wr,
    input wire logic             interrupt,
    input wire logic             interrupt_s,
    input wire logic [7:0]       master_quality_monitor_reg,
    input wire logic             comm_fault,
    input wire logic             link,
    input wire mss_fast_evt_t    fast_evt,
    input wire logic             pos_ready_all,
    input wire logic             fast_pos_rdy,
    input wire logic             synchronizing,
    input wire logic             sync_locked,
    input wire logic             bit_sampled,
    input wire logic             sample,
    input wire mss_safe_evt_t    safe_evt,
    input wire logic [DEV_W-1:0] max_deviation,
    input wire logic [DEV_W-1:0] worst_dev,
    input wire logic             estimator_on,
    input wire logic             dev_thr_err,
    input wire logic             safe_channel_err,
    input wire logic             acceleration_err,
    input wire logic [CNT_W-1:0] acc_thr,
    input wire logic [CNT_W-1:0] acc_err_cnt,
    input wire logic             acc_thr_err,
    input wire logic             frame_done,
    input wire logic             frame_code_err,
    input wire logic             encoding_err
);
    // ************
    // Assertions.
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_drive_wr_mask: assert property (drive_event_wr |=> !interrupt)
        else $error("drive interrupt not masked during write");
    a_safe_wr_mask: assert property (safe_event_wr |=> !interrupt_s)
        else $error("safety interrupt not masked during write");
    a_drive_int_cause: assert property (interrupt |-> $past(|(drive_event & drive_mask)))
        else $error("drive interrupt without pending condition");
    a_safe_int_cause: assert property (interrupt_s |-> $past(|(safe_event & safe_mask)))
        else $error("safety interrupt without pending condition");
    a_link_level: assert property (link == (master_quality_monitor_reg[7] && !comm_fault))
        else $error("link level wrong");
    a_pos_rdy_pulse: assert property (fast_evt.fast_new && (pos_ready_all ||
        fast_evt.fast_requested) |=> fast_pos_rdy) else $error("position ready missing");
    a_pos_rdy_quiet: assert property (!fast_evt.fast_new |=> !fast_pos_rdy)
        else $error("position ready without new position");
    a_lock_sync: assert property (synchronizing |=> !sync_locked)
        else $error("locked while synchronizing");
    a_sample_lag: assert property (bit_sampled |-> ##2 sample)
        else $error("sample pulse late or missing");
    a_est_cause: assert property (fast_evt.fast_new && (fast_evt.fast_enc_err ||
        fast_evt.fast_crc_err) |=> estimator_on) else $error("estimator flag missing");
    a_dev_thr: assert property (dev_thr_err == (worst_dev > max_deviation))
        else $error("deviation threshold flag wrong");
    a_acc_cnt_zero: assert property (!acceleration_err && !$past(acceleration_err)
        |-> acc_err_cnt == '0) else $error("error counter not cleared");
    a_acc_thr: assert property (acc_thr_err == (acc_err_cnt > acc_thr))
        else $error("acceleration threshold flag wrong");
    a_code_err: assert property (frame_done && frame_code_err |=> encoding_err)
        else $error("coding error flag missing");
    a_safe_ch: assert property (safe_evt.safe_new && safe_evt.safe_crc_err
        |=> safe_channel_err) else $error("safe channel error missing");

    c_pos_rdy: cover property (fast_pos_rdy);
    c_locked: cover property (sync_locked);
    c_acc_thr: cover property (acc_thr_err);
endmodule : mss_checker

bind mss_status_outputs mss_checker #(.CNT_W(CNT_W), .DEV_W(DEV_W)) u_chk (.*);

// File: tb/mss_host_app.sv
`timescale 1ns/1ps
module mss_host_app #(
    parameter int HALF = 8
)
(
    input  wire logic clk,
    input  wire logic run,
    input  wire logic pol,
    output logic      sync
);
    // ************
    // Trigger generator.
    // ************
    int   cnt = 0;
    logic ph  = 1'b0;

    always @(posedge clk)
    begin
        cnt <= (cnt == HALF - 1 || !run) ? 0 : cnt + 1;
        if (!run)
            ph <= 1'b0;
        else if (cnt == HALF - 1)
            ph <= !ph;
    end
    assign sync = ph ^ !pol;
endmodule : mss_host_app

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import mss_pkg::*;
    logic          clk = 1'b0;
    logic          resetn, drive_event_wr, safe_event_wr, spi_ss_n, interrupt, interrupt_s;
    logic [15:0]   drive_event, drive_mask, acc_limit, max_deviation, worst_dev;
    logic [7:0]    safe_event, safe_mask, master_quality_monitor_reg, host_addr;
    logic [7:0]    acc_thr, acc_err_cnt;
    logic          comm_fault, link, pos_ready_all, fast_pos_rdy, sync, host_run;
    logic          trigger_edge_polarity, frame_sync_tick, synchronizing, sync_edge;
    logic          sync_locked, bigend, bit_sampled, sample, estimator_on, dev_thr_err;
    logic          safe_channel_err, safe_pos_err, acceleration_err, acc_thr_err;
    logic          frame_done, frame_code_err, encoding_err;
    logic [31:0]   safe_pos, est_pos;
    mss_fast_evt_t fast_evt;
    mss_safe_evt_t safe_evt;
    mss_blk_t      host_blk;
    mss_dec_t      host_dec;
    int            n_mismatch = 0;
    int            cmp_count = 0;
    int            cycles = 0;

    mss_status_outputs DUT (.*);
    mss_host_app host (.clk(clk), .run(host_run), .pol(trigger_edge_polarity), .sync(sync));

    // ************
    // Helpers.
    // ************
    always #12.5 clk = !clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task give_verdict;
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // ************
    // Scenarios.
    // ************
    task t_irq;
        {drive_event, drive_mask, safe_event, safe_mask} = {16'h0001, 16'h0001, 8'h80, 8'h80};
        cyc(2);
        check({interrupt, interrupt_s}, 2'h3);
        for (int k = 0; k < 2; k++)
        begin
            spi_ss_n = 1'b0;
            cyc(3);
            {drive_event_wr, safe_event_wr} = k[0] ? 2'h1 : 2'h2;
            cyc(1);
            {drive_event_wr, safe_event_wr} = 2'h0;
            cyc(3);
            check({interrupt, interrupt_s}, k[0] ? 2'h2 : 2'h1);
            spi_ss_n = 1'b1;
            for (int i = 0; i < 8 && {interrupt, interrupt_s} !== 2'h3; i++)
                cyc(1);
            check({interrupt, interrupt_s}, 2'h3);
        end
        safe_mask = 8'h00;
        drive_event = 16'h0000;
        cyc(2);
        check({interrupt, interrupt_s}, 2'h0);
    endtask : t_irq

    task t_link;
        for (int k = 0; k < 4; k++)
        begin
            master_quality_monitor_reg = {k[0], 7'h55};
            comm_fault = k[1];
            cyc(1);
            check(link, k[0] & !k[1]);
        end
        comm_fault = 1'b0;
    endtask : t_link

    task t_pos;
        safe_pos = 32'h0000_1100;
        safe_evt = '{safe_new: 1'b1, default: 1'b0};
        max_deviation = 16'h003F;
        cyc(1);
        safe_evt = '0;
        for (int k = 0; k < 4; k++)
        begin
            pos_ready_all = k[1];
            fast_evt = '{fast_new: 1'b1, fast_requested: k[0], fast_enc_err: 1'b1, default: 1'b0};
            cyc(1);
            check(fast_pos_rdy, k[1] | k[0]);
            check(estimator_on, 1);
            check(dev_thr_err, k == 3);
        end
        fast_evt = '0;
        check(dev_thr_err, 1);
        check(worst_dev, 16'h0040);
        check(est_pos, 32'h0000_1200);
    endtask : t_pos

    task t_acc;
        acc_thr = 8'h01;
        for (int i = 0; i < 4; i++)
        begin
            fast_evt = '{fast_new: 1'b1, acc_invalid: 1'b1, default: 1'b0};
            cyc(1);
        end
        fast_evt = '{fast_new: 1'b1, default: 1'b0};
        check({acceleration_err, acc_thr_err}, 2'h3);
        cyc(1);
        fast_evt = '0;
        cyc(1);
        check({acceleration_err, acc_err_cnt}, 9'h000);
    endtask : t_acc

    task t_safe;
        check(safe_pos_err, 1);
        safe_evt = '{safe_new: 1'b1, safe_crc_err: 1'b1, default: 1'b0};
        cyc(1);
        check(safe_channel_err, 1);
        safe_evt = '{safe_new: 1'b1, default: 1'b0};
        cyc(1);
        safe_evt = '0;
        cyc(1);
        check({safe_channel_err, safe_pos_err}, 2'h0);
        safe_evt = '{safe_new: 1'b1, enc_pos_err: 1'b1, default: 1'b0};
        frame_done = 1'b1;
        frame_code_err = 1'b1;
        cyc(1);
        {safe_evt, frame_done, frame_code_err} = '0;
        check({safe_pos_err, encoding_err}, 2'h3);
    endtask : t_safe

    task t_dec;
        logic [19:0] tv [6] = '{{2'h0, 1'b0, 8'h41, 9'h1C1}, {2'h0, 1'b1, 8'h41, 9'h1C2},
            {2'h1, 1'b0, 8'h7F, 9'h1FF}, {2'h2, 1'b1, 8'h3F, 9'h13C},
            {2'h2, 1'b0, 8'h40, 9'h000}, {2'h0, 1'b0, 8'h80, 9'h000}};
        for (int i = 0; i < 6; i++)
        begin
            {bigend, host_addr} = tv[i][17:9];
            host_blk = mss_blk_t'(tv[i][19:18]);
            cyc(1);
            if (tv[i][8])
                check(host_dec, tv[i][8:0]);
            else
                check(host_dec.valid, 0);
        end
    endtask : t_dec

    task t_sample;
        int n;
        n = 0;
        for (int i = 0; i < 64; i++)
        begin
            bit_sampled = (i < 61 && i != 50);
            cyc(1);
            n += (sample === 1'b1);
        end
        check(n, 60);
    endtask : t_sample

    task t_lock;
        logic [3:0] hist;
        hist = 4'h0;
        synchronizing = 1'b1;
        host_run = 1'b1;
        cyc(4);
        check(sync_locked, 0);
        synchronizing = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            trigger_edge_polarity = k[0];
            for (int i = 0; i < 40; i++)
            begin
                hist = {hist[2:0], sync_edge};
                frame_sync_tick = (k < 2) ? hist[0] : hist[k];
                cyc(1);
            end
            check(sync_locked, k < 3);
        end
        frame_sync_tick = 1'b0;
        host_run = 1'b0;
    endtask : t_lock

    initial
    begin
        resetn = 1'b0;
        {drive_event, drive_mask, safe_event, safe_mask, drive_event_wr, safe_event_wr} = '0;
        {comm_fault, pos_ready_all, frame_sync_tick, synchronizing, bigend, host_run} = '0;
        {bit_sampled, frame_done, frame_code_err, fast_evt, safe_evt, host_addr} = '0;
        {acc_thr, max_deviation} = '0;
        spi_ss_n = 1'b1;
        trigger_edge_polarity = 1'b1;
        master_quality_monitor_reg = 8'h80;
        host_blk = MSS_BLK_DRIVE;
        safe_pos = 32'h0000_1000;
        acc_limit = 16'h0010;
        cyc(4);
        resetn = 1'b1;
        cyc(3);
        check({interrupt, interrupt_s}, 2'h0);
        t_safe();
        t_irq();
        t_link();
        t_pos();
        t_acc();
        t_dec();
        t_sample();
        t_lock();
        give_verdict();
    end
endmodule : testbench
